/* irs_pkg.sv */
package irs_pkg;
    localparam int           WORD_W        = 14;
    localparam int           DATA_W        = 8;
    localparam int           ADDR_W        = 7;
    localparam int           PC_W          = 13;
    // opcode field, bits 13:8 of the word (top two bits zero)
    localparam logic [5:0]   OP_INCR       = 6'h0a;
    localparam logic [5:0]   OP_ROT_LEFT   = 6'h0d;
    localparam logic [5:0]   OP_ROT_RIGHT  = 6'h0c;
    localparam logic [13:0]  OP_SLEEP      = 14'h0063;
    localparam int           DEST_BIT      = 7;
    localparam logic [12:0]  IRQ_VECTOR    = 13'h0004;
    localparam logic [7:0]   WDOG_CLEAR    = 8'h00;
    localparam logic [7:0]   PRESC_CLEAR   = 8'h00;
    localparam logic [7:0]   ACC_RESET     = 8'h00;
    localparam logic [12:0]  PC_RESET      = 13'h0000;
endpackage : irs_pkg

/* irs_file_ram.sv */
`timescale 1ns/1ns
`default_nettype none
module irs_file_ram #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    // clock
    input  wire logic          clk,
    // read port, registered data
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data,
    // write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data
);
    // contents start cleared so that the first read of any cell is defined
    logic [DW-1:0] mem [0:(1<<AW)-1] = '{default: '0};

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk)
    begin
        rd_data <= mem[rd_addr];
    end
endmodule : irs_file_ram
`default_nettype wire

/* irs_exec.sv */
`timescale 1ns/1ns
`default_nettype none
// Operation
// RL1: word 00 1010 d fffffff adds one to the addressed file register.
// RL2: destination bit 0 writes the accumulator, 1 writes the file register.
// RL3: increment changes only zero flag; 0xff wraps to 0x00, sets zero.
// RL4: opcode 1101 rotates left through carry; bit 7 into carry.
// RL5: opcode 1100 rotates right through carry; bit 0 into carry.
// RL6: low-power instruction clears the sleep marker bit.
// RL7: low-power instruction sets the expiry flag together.
// RL8: low-power instruction zeroes watchdog counter and its prescaler.
// RL9: after low-power instruction the core sleeps, clock halted, until wake-up.
// RL10: any wake-up from sleep clears the watchdog counter.
// RL11: enabled interrupt wakes; with global enable, run next then vector 0004h.
// RL12: low-power instruction prefetches the word at the next address.
// RL13: each of these instructions takes one cycle and one word.
module irs_exec
    import irs_pkg::*;
(
    // clock and reset
    input  wire logic                        CLK,
    input  wire logic                        RESET,
    // fetched instruction
    input  wire logic [irs_pkg::WORD_W-1:0]  INSTR,
    input  wire logic                        INSTR_VALID,
    // wake-up interrupt, its vector enable and the watchdog tick (not counted in sleep)
    input  wire logic                        WAKE_IRQ,
    input  wire logic                        GLOBAL_IRQ_ENABLE,
    input  wire logic                        WDOG_TICK,
    // state
    output logic      [irs_pkg::DATA_W-1:0]  ACC,
    output logic                             CARRY,
    output logic                             ZERO,
    output logic                             SLEEP_MARKER_BIT,
    output logic                             EXPIRY_FLAG,
    output logic      [irs_pkg::DATA_W-1:0]  WATCHDOG_COUNTER,
    output logic      [irs_pkg::DATA_W-1:0]  WDOG_PRESCALER,
    output logic                             SLEEPING,
    output logic                             OSC_RUN,
    output logic      [irs_pkg::PC_W-1:0]    PC,
    output logic      [irs_pkg::PC_W-1:0]    FETCH_ADDR,
    output logic                             IRQ_TAKEN,
    output logic                             BUSY,
    // file register read back
    output logic      [irs_pkg::DATA_W-1:0]  FILE_RD_DATA
);
    import irs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        ST_READ  = 3'b001,
        ST_EXEC  = 3'b010,
        ST_SLEEP = 3'b100
    } irs_state_t;

    irs_state_t              state;
    logic [WORD_W-1:0]       word;
    logic [DATA_W-1:0]       rd_data;
    logic [DATA_W-1:0]       result;
    logic                    next_carry;
    logic                    wr_file;
    logic                    is_incr;
    logic                    is_rl;
    logic                    is_rr;
    logic                    is_sleep;
    logic                    pend_vector;
    logic                    next_sleeping;

    assign is_incr  = (word[13:8] == OP_INCR);              // RL1
    assign is_rl    = (word[13:8] == OP_ROT_LEFT);          // RL4
    assign is_rr    = (word[13:8] == OP_ROT_RIGHT);         // RL5
    assign is_sleep = (word == OP_SLEEP);                   // RL6

    ////////////////////////////////////////////////////////////////////////
    // data path
    always_comb
    begin
        result     = rd_data;
        next_carry = CARRY;
        if (is_incr)
        begin
            result = rd_data + 8'h01;                       // RL1 RL3
        end
        else if (is_rl)
        begin
            result     = {rd_data[6:0], CARRY};             // RL4
            next_carry = rd_data[7];                        // RL4
        end
        else if (is_rr)
        begin
            result     = {CARRY, rd_data[7:1]};             // RL5
            next_carry = rd_data[0];                        // RL5
        end
    end

    assign wr_file = (state == ST_EXEC) && (is_incr || is_rl || is_rr) && word[DEST_BIT]; // RL2

    irs_file_ram #(
        .AW (ADDR_W),
        .DW (DATA_W)
    ) u_ram (
        .clk     (CLK),
        .rd_addr (INSTR[ADDR_W-1:0]),
        .rd_data (rd_data),
        .wr_en   (wr_file),
        .wr_addr (word[ADDR_W-1:0]),
        .wr_data (result)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencing: read cycle then execute cycle form one instruction cycle
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            state <= ST_READ;
            word  <= '0;
        end
        else
        begin
            unique case (state)
                ST_READ:
                begin
                    if (INSTR_VALID)
                    begin
                        word  <= INSTR;
                        state <= ST_EXEC;                   // RL13
                    end
                end
                ST_EXEC:
                begin
                    state <= is_sleep ? ST_SLEEP : ST_READ; // RL9
                end
                ST_SLEEP:
                begin
                    if (WAKE_IRQ)
                    begin
                        state <= ST_READ;                   // RL11
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // accumulator and flags
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ACC   <= ACC_RESET;
            CARRY <= 1'b0;
            ZERO  <= 1'b0;
        end
        else if (state == ST_EXEC)
        begin
            if ((is_incr || is_rl || is_rr) && !word[DEST_BIT])
            begin
                ACC <= result;                              // RL2
            end
            if (is_incr)
            begin
                ZERO <= (result == 8'h00);                  // RL3
            end
            if (is_rl || is_rr)
            begin
                CARRY <= next_carry;                        // RL4 RL5
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power-down status and watchdog
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            SLEEP_MARKER_BIT <= 1'b1;
            EXPIRY_FLAG      <= 1'b1;
            WATCHDOG_COUNTER <= WDOG_CLEAR;
            WDOG_PRESCALER   <= PRESC_CLEAR;
        end
        else if (state == ST_EXEC && is_sleep)
        begin
            SLEEP_MARKER_BIT <= 1'b0;                       // RL6
            EXPIRY_FLAG      <= 1'b1;                       // RL7
            WATCHDOG_COUNTER <= WDOG_CLEAR;                 // RL8
            WDOG_PRESCALER   <= PRESC_CLEAR;                // RL8
        end
        else if (state == ST_SLEEP && WAKE_IRQ)
        begin
            WATCHDOG_COUNTER <= WDOG_CLEAR;                 // RL10
            WDOG_PRESCALER   <= PRESC_CLEAR;
        end
        else if (WDOG_TICK && state != ST_SLEEP)
        begin
            WDOG_PRESCALER <= WDOG_PRESCALER + 8'h01;
            if (WDOG_PRESCALER == 8'hff)
            begin
                WATCHDOG_COUNTER <= WATCHDOG_COUNTER + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // program counter, prefetch and interrupt vectoring
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            PC          <= PC_RESET;
            FETCH_ADDR  <= PC_RESET;
            pend_vector <= 1'b0;
            IRQ_TAKEN   <= 1'b0;
        end
        else
        begin
            IRQ_TAKEN <= 1'b0;
            if (state == ST_EXEC)
            begin
                if (pend_vector)
                begin
                    PC          <= IRQ_VECTOR;              // RL11
                    FETCH_ADDR  <= IRQ_VECTOR;
                    pend_vector <= 1'b0;
                    IRQ_TAKEN   <= 1'b1;
                end
                else
                begin
                    PC         <= PC + 13'h0001;            // RL13
                    FETCH_ADDR <= PC + 13'h0001;            // RL12
                end
            end
            else if (state == ST_SLEEP && WAKE_IRQ && GLOBAL_IRQ_ENABLE)
            begin
                pend_vector <= 1'b1;                        // RL11
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered status outputs
    assign next_sleeping = (state == ST_EXEC && is_sleep) || (state == ST_SLEEP && !WAKE_IRQ);

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            SLEEPING     <= 1'b0;
            OSC_RUN      <= 1'b1;
            BUSY         <= 1'b0;
            FILE_RD_DATA <= 8'h00;
        end
        else
        begin
            SLEEPING     <= next_sleeping;                  // RL9
            OSC_RUN      <= !next_sleeping;                 // RL9
            BUSY         <= (state == ST_READ && INSTR_VALID);
            FILE_RD_DATA <= rd_data;
        end
    end
endmodule : irs_exec
`default_nettype wire

/* irs_exec_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module irs_exec_checker
    import irs_pkg::*;
(
    // clock, reset and inputs
    input wire logic                        CLK,
    input wire logic                        RESET,
    input wire logic [irs_pkg::WORD_W-1:0]  INSTR,
    input wire logic                        INSTR_VALID,
    input wire logic                        WAKE_IRQ,
    // outputs watched
    input wire logic [irs_pkg::DATA_W-1:0]  ACC,
    input wire logic                        CARRY,
    input wire logic                        ZERO,
    input wire logic                        SLEEP_MARKER_BIT,
    input wire logic                        EXPIRY_FLAG,
    input wire logic [irs_pkg::DATA_W-1:0]  WATCHDOG_COUNTER,
    input wire logic [irs_pkg::DATA_W-1:0]  WDOG_PRESCALER,
    input wire logic                        SLEEPING,
    input wire logic                        OSC_RUN,
    input wire logic [irs_pkg::PC_W-1:0]    PC,
    input wire logic                        IRQ_TAKEN,
    input wire logic                        BUSY
);
    import irs_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    wire logic take = INSTR_VALID && !BUSY && !SLEEPING;
    wire logic rotl = take && INSTR[13:8] == OP_ROT_LEFT && !INSTR[DEST_BIT];
    wire logic rotr = take && INSTR[13:8] == OP_ROT_RIGHT && !INSTR[DEST_BIT];
    wire logic incr = take && INSTR[13:8] == OP_INCR;
    wire logic slp  = take && INSTR == OP_SLEEP;
    property p_busy; take |=> BUSY ##1 !BUSY; endproperty
    a_busy: assert property (p_busy) else $error("busy not one cycle");
    property p_zero; incr && !INSTR[DEST_BIT] |-> ##2 (ZERO == (ACC == 8'h00)); endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_incc; incr |-> ##2 $stable(CARRY); endproperty
    a_incc: assert property (p_incc) else $error("increment moved carry");
    property p_rotl; rotl |-> ##2 (ACC[0] == $past(CARRY, 2)); endproperty
    a_rotl: assert property (p_rotl) else $error("left rotate bit 0 wrong");
    property p_rotr; rotr |-> ##2 (ACC[7] == $past(CARRY, 2)); endproperty
    a_rotr: assert property (p_rotr) else $error("right rotate bit 7 wrong");
    property p_rotz; rotl || rotr |-> ##2 $stable(ZERO); endproperty
    a_rotz: assert property (p_rotz) else $error("rotate moved zero");
    property p_slp;
        slp |-> ##2 (!SLEEP_MARKER_BIT && EXPIRY_FLAG && SLEEPING
            && WATCHDOG_COUNTER == WDOG_CLEAR && WDOG_PRESCALER == PRESC_CLEAR);
    endproperty
    a_slp: assert property (p_slp) else $error("sleep entry wrong");
    property p_osc; SLEEPING |-> !OSC_RUN; endproperty
    a_osc: assert property (p_osc) else $error("oscillator runs in sleep");
    property p_hold; SLEEPING && !WAKE_IRQ |=> $stable(PC) && $stable(ACC); endproperty
    a_hold: assert property (p_hold) else $error("work done in sleep");
    property p_wake; SLEEPING && WAKE_IRQ |=> !SLEEPING && WATCHDOG_COUNTER == WDOG_CLEAR;
    endproperty
    a_wake: assert property (p_wake) else $error("wake wrong");
    property p_vec; IRQ_TAKEN |-> PC == IRQ_VECTOR; endproperty
    a_vec: assert property (p_vec) else $error("vector wrong");
    c_slp: cover property (slp);
    c_wake: cover property (SLEEPING && WAKE_IRQ);
    c_irq: cover property (IRQ_TAKEN);
endmodule : irs_exec_checker
bind irs_exec irs_exec_checker irs_exec_checker_inst (.CLK(CLK), .RESET(RESET), .INSTR(INSTR),
    .INSTR_VALID(INSTR_VALID), .WAKE_IRQ(WAKE_IRQ), .ACC(ACC), .CARRY(CARRY), .ZERO(ZERO),
    .SLEEP_MARKER_BIT(SLEEP_MARKER_BIT), .EXPIRY_FLAG(EXPIRY_FLAG), .PC(PC), .BUSY(BUSY),
    .WATCHDOG_COUNTER(WATCHDOG_COUNTER), .WDOG_PRESCALER(WDOG_PRESCALER),
    .SLEEPING(SLEEPING), .OSC_RUN(OSC_RUN), .IRQ_TAKEN(IRQ_TAKEN));
`default_nettype wire

/* tb_incr_rotate_sleep_exec.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_incr_rotate_sleep_exec;
    import irs_pkg::*;
    logic        CLK = 0, RESET = 1, INSTR_VALID = 0, WAKE_IRQ = 0, WDOG_TICK = 0;
    logic        GLOBAL_IRQ_ENABLE = 0;
    logic [13:0] INSTR = 0;
    logic [7:0]  ACC, WATCHDOG_COUNTER, WDOG_PRESCALER, FILE_RD_DATA, m_acc, m_ram [128];
    logic        CARRY, ZERO, SLEEP_MARKER_BIT, EXPIRY_FLAG, SLEEPING, OSC_RUN, IRQ_TAKEN, BUSY;
    logic        m_c, m_z, known [128];
    logic [12:0] PC, FETCH_ADDR, m_pc;
    int          fails = 0, checks = 0, seed = 32'h57cf9550;
    irs_exec irs_exec_inst (.CLK(CLK), .RESET(RESET), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
        .WAKE_IRQ(WAKE_IRQ), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
        .WDOG_TICK(WDOG_TICK), .ACC(ACC),
        .CARRY(CARRY), .ZERO(ZERO), .SLEEP_MARKER_BIT(SLEEP_MARKER_BIT), .OSC_RUN(OSC_RUN),
        .EXPIRY_FLAG(EXPIRY_FLAG), .WATCHDOG_COUNTER(WATCHDOG_COUNTER), .PC(PC), .BUSY(BUSY),
        .WDOG_PRESCALER(WDOG_PRESCALER), .SLEEPING(SLEEPING), .FETCH_ADDR(FETCH_ADDR),
        .IRQ_TAKEN(IRQ_TAKEN), .FILE_RD_DATA(FILE_RD_DATA));
    always #4 CLK = ~CLK;
    task automatic give_verdict;
        if (fails == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input string n, input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s exp %h got %h", n, exp, got);
        end
    endtask : chk
    function automatic logic [8:0] calc(input logic [5:0] op, input logic [7:0] v, input logic c);
        if (op == OP_INCR)
            return {c, v + 8'h01};
        if (op == OP_ROT_LEFT)
            return {v[7], v[6:0], c};
        return {v[0], c, v[7:1]};
    endfunction : calc
    // one word: take edge, then result edge
    task automatic exec(input logic [13:0] w, input logic irq);
        INSTR = w;
        INSTR_VALID = 1;
        @(posedge CLK) #1;
        INSTR_VALID = 0;
        chk("BUSY", BUSY, 1);
        @(posedge CLK) #1;
        m_pc = irq ? IRQ_VECTOR : m_pc + 13'h0001;
        chk("BUSY", BUSY, 0);
        chk("PC", PC, m_pc);
        chk("IRQ", IRQ_TAKEN, irq);
    endtask : exec
    task automatic do_op(input logic [5:0] op, input logic d, input logic [6:0] f, input logic irq);
        logic [8:0] r;
        if (known[f] !== 1'b1)
        begin
            exec({OP_INCR, 1'b0, f}, 0);
            chk("RAMX", $isunknown(ACC), '0);
            m_ram[f] = ACC - 8'h01;
            m_acc = ACC;
            m_z = (ACC == 8'h00);
            known[f] = 1;
        end
        r = calc(op, m_ram[f], m_c);
        exec({op, d, f}, irq);
        chk("FILE_RD", FILE_RD_DATA, m_ram[f]);
        if (d)
            m_ram[f] = r[7:0];
        else
            m_acc = r[7:0];
        if (op == OP_INCR)
            m_z = (r[7:0] == 8'h00);
        else
            m_c = r[8];
        chk("ACC", ACC, m_acc);
        chk("FLAGS", {CARRY, ZERO}, {m_c, m_z});
    endtask : do_op
    task automatic rst;
        RESET = 1;
        repeat (6) @(posedge CLK);
        #1 RESET = 0;
        {m_pc, m_acc, m_c, m_z} = '0;
        chk("RST", {ACC, CARRY, ZERO, SLEEP_MARKER_BIT, EXPIRY_FLAG, OSC_RUN}, 13'h0007);
        chk("RSTPC", PC, '0);
    endtask : rst
    initial
    begin
        #60000 fails++;
        give_verdict();
    end
    initial
    begin
        logic [31:0] r;
        rst();
        repeat (256) do_op(OP_INCR, 1, 7'h7f, 0);
        repeat (60)
        begin
            r = $random(seed);
            do_op(r[1] ? OP_INCR : r[0] ? OP_ROT_LEFT : OP_ROT_RIGHT, r[2],
                r[3] ? 7'h7f : {4'h0, r[6:4]}, 0);
        end
        for (int g = 0; g < 2; g++)
        begin
            WDOG_TICK = 1;
            repeat (256) @(posedge CLK) #1;
            WDOG_TICK = 0;
            chk("WDOG", {WDOG_PRESCALER, WATCHDOG_COUNTER}, 16'h0001);
            GLOBAL_IRQ_ENABLE = g[0];
            exec(OP_SLEEP, 0);
            chk("SLP", {SLEEP_MARKER_BIT, EXPIRY_FLAG, SLEEPING, OSC_RUN}, 4'h6);
            chk("WDOG", {WDOG_PRESCALER, WATCHDOG_COUNTER}, 0);
            chk("FETCH", FETCH_ADDR, m_pc);
            INSTR = {OP_INCR, 1'b0, 7'h7f};
            INSTR_VALID = 1;
            repeat (4) @(posedge CLK) #1;
            INSTR_VALID = 0;
            chk("SLPHOLD", {PC, ACC}, {m_pc, m_acc});
            WAKE_IRQ = 1;
            @(posedge CLK) #1;
            WAKE_IRQ = 0;
            chk("WAKE", {SLEEPING, WATCHDOG_COUNTER}, 0);
            do_op(OP_ROT_LEFT, 0, 7'h7f, g[0]);
            GLOBAL_IRQ_ENABLE = 0;
        end
        rst();
        give_verdict();
    end
endmodule : tb_incr_rotate_sleep_exec
`default_nettype wire
